// ===== dsc_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
// far-side memory: one strobe burst per go pulse
module dsc_mem_model #(
  parameter int N = 2
) (
  // clock and burst start
  input wire logic clk,
  input wire logic go,
  // read strobes toward the device
  output logic [N-1:0] strobe
);
  int ph = 0; // burst step, 0 while released
  // step through preamble, burst, postamble
  always @(posedge clk) begin
    if (go) ph <= 1;
    else if (ph != 0) ph <= (ph == 18) ? 0 : ph + 1;
  end
  // low around the burst, two cycles per level inside it so the pin filter follows
  always_comb begin
    if (ph == 0) strobe = '1; // released: all strobes driven high
    else if (ph < 4 || ph > 15) strobe = '0;
    else strobe = {N{~ph[1]}};
  end
endmodule : dsc_mem_model
`default_nettype wire

// ===== dsc_pkg.sv
`default_nettype none
package dsc_pkg;
  // register port
  localparam int DATA_W = 32;
  localparam int ADDR_W = 4;
  localparam logic [3:0] REG_CTRL = 4'h0; // mode bits and loop restart
  localparam logic [3:0] REG_PHASE = 4'h1; // phase-offset setting
  localparam logic [3:0] REG_LVL = 4'h2; // leveling tap selects, one byte per group
  localparam logic [3:0] REG_STATUS = 4'h3; // lock, held and loop settings
  // control bit positions
  localparam int CTRL_CORE_DLY = 0; // 1: core supplies the delay setting
  localparam int CTRL_UPD_USER = 1; // 1: update enable paced by user tick
  localparam int CTRL_HR_STAGE = 2; // 1: half_rate_stage first capture in gate path
  localparam int CTRL_DLL_RST = 3; // write 1: restart loop and lock timer
  // status bit positions
  localparam int STAT_LOCK = 0;
  localparam int STAT_HELD_LSB = 8;
  localparam int STAT_DLL_LSB = 16;
  // leveling select layout
  localparam int LVL_GRP_W = 8;
  localparam int LVL_WR_LSB = 3;
  // setting and tap widths
  localparam int SET_W = 7;
  localparam int TAP_W = 3;
  localparam int TAP_IDX_LSB = 4; // top bits of setting pick the strobe delay tap
  localparam logic [2:0] LAG_90 = 3'h2; // two 45 degree taps
  localparam logic [2:0] HALF_TAPS = 3'h4; // half of an eight-tap period
  // loop lock time in reference clock cycles
  localparam logic [11:0] LOCK_CYCLES = 12'hA00;
  localparam logic [6:0] GRAY_RST = 7'h00;
  localparam logic [6:0] GRAY_MAX_BIN = 7'h7F;

  // mode bits held in the control register
  typedef struct packed {
    logic hr_stage;
    logic upd_user;
    logic core_delay;
  } dsc_cfg_t;

  // settings that travel together into the delay chains
  typedef struct packed {
    logic [6:0] delay;
    logic [6:0] phase;
  } dsc_set_t;

  // gray to binary
  function automatic logic [6:0] gray2bin(input logic [6:0] g);
    logic [6:0] b;
    b[6] = g[6];
    for (int i = 5; i >= 0; i--) begin
      b[i] = b[i+1] ^ g[i];
    end
    return b;
  endfunction : gray2bin

  // binary to gray
  function automatic logic [6:0] bin2gray(input logic [6:0] b);
    return b ^ (b >> 1);
  endfunction : bin2gray
endpackage : dsc_pkg
`default_nettype wire

// ===== dsc_strobe_logic.sv
// How it works
// - each strobe pin has its own logic
// - delay and phase settings held before chains
// - holding registers load only on update enable
// - update enable paced by reference or user
// - core may supply gray delay setting
// - processor variant uses loop setting only
// - shifted strobe forced low after reads
// - half_rate_stage clocked by half-rate divider
// - postamble register outputs are ANDed
// - gate on after one cycle, off immediately
// - eight 45 degree taps shared per sub-bank
// - each group picks read/write tap independently
// - leveling chain ignores the held setting
// - write leveling driven by -90 write clock
// - data clock lags strobe clock 90 degrees
// - termination on for reads, off writes
// - data and strobe write clocks 90 apart
// - loop setting is up/down gray counter
`timescale 1ns/1ps
`default_nettype none
module dsc_strobe_logic #(
  parameter int NUM_STROBES = 2, // strobe pins, one block each
  parameter bit HAS_PROCESSOR = 1'b0, // processor variant: no core setting path
  parameter logic [7:0] UPD_PERIOD = 8'h08 // pacing ticks between update pulses
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  // register port
  input wire logic [dsc_pkg::ADDR_W-1:0] addr,
  input wire logic [dsc_pkg::DATA_W-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [dsc_pkg::DATA_W-1:0] rdata,
  // loop phase comparator and setting sources
  input wire logic pd_valid,
  input wire logic pd_up,
  input wire logic [dsc_pkg::SET_W-1:0] core_delay_gray,
  input wire logic ref_tick,
  input wire logic user_tick,
  // strobe pins and gate enables
  input wire logic [NUM_STROBES-1:0] strobe_pin,
  input wire logic [NUM_STROBES-1:0] gate_en,
  output logic [NUM_STROBES-1:0] dq_capture_strobe,
  // settings and update
  output logic upd_en,
  output logic [dsc_pkg::SET_W-1:0] held_delay,
  output logic [dsc_pkg::SET_W-1:0] held_phase,
  output logic locked,
  // write path and termination
  input wire logic rd_active,
  input wire logic wr_active,
  output logic parallel_termination,
  output logic wr_strobe_clk,
  output logic wr_data_clk,
  // leveled clocks per group
  output logic [NUM_STROBES-1:0] rl_clk,
  output logic [NUM_STROBES-1:0] wl_strobe_clk,
  output logic [NUM_STROBES-1:0] wl_data_clk
);

  // register state
  dsc_pkg::dsc_cfg_t cfg_q, cfg_d; // mode bits
  logic [6:0] phase_reg_q, phase_reg_d; // written phase offset
  logic [31:0] lvl_q, lvl_d; // tap selects
  logic [31:0] rdata_q, rdata_d; // read answer
  logic dll_rst; // restart pulse from a control write
  // loop counter, lock timer, update pacing
  logic [6:0] dll_gray_q, dll_gray_d; // loop delay setting, gray coded
  logic [11:0] lock_cnt_q, lock_cnt_d; // cycles since loop restart
  logic locked_q, locked_d;
  logic [7:0] upd_cnt_q, upd_cnt_d; // pacing tick count
  logic upd_en_q, upd_en_d;
  dsc_pkg::dsc_set_t held_q, held_d; // settings seen by the chains
  logic [6:0] sel_delay; // setting offered to the holding register
  logic pace_tick; // selected pacing source
  logic [6:0] dll_bin; // loop setting in binary

  // register decode
  always_comb begin
    cfg_d = cfg_q;
    phase_reg_d = phase_reg_q;
    lvl_d = lvl_q;
    rdata_d = '0;
    dll_rst = 1'b0;
    if (wr) begin
      unique case (addr)
        dsc_pkg::REG_CTRL: begin
          cfg_d.core_delay = wdata[dsc_pkg::CTRL_CORE_DLY];
          cfg_d.upd_user = wdata[dsc_pkg::CTRL_UPD_USER];
          cfg_d.hr_stage = wdata[dsc_pkg::CTRL_HR_STAGE];
          dll_rst = wdata[dsc_pkg::CTRL_DLL_RST];
        end
        dsc_pkg::REG_PHASE: phase_reg_d = wdata[dsc_pkg::SET_W-1:0];
        dsc_pkg::REG_LVL: lvl_d = wdata;
        default: ; // unmapped writes ignored
      endcase
    end
    if (rd) begin
      unique case (addr)
        dsc_pkg::REG_CTRL: begin
          rdata_d[dsc_pkg::CTRL_CORE_DLY] = cfg_q.core_delay;
          rdata_d[dsc_pkg::CTRL_UPD_USER] = cfg_q.upd_user;
          rdata_d[dsc_pkg::CTRL_HR_STAGE] = cfg_q.hr_stage;
        end
        dsc_pkg::REG_PHASE: rdata_d[dsc_pkg::SET_W-1:0] = phase_reg_q;
        dsc_pkg::REG_LVL: rdata_d = lvl_q;
        dsc_pkg::REG_STATUS: begin
          rdata_d[dsc_pkg::STAT_LOCK] = locked_q;
          rdata_d[dsc_pkg::STAT_HELD_LSB +: dsc_pkg::SET_W] = held_q.delay;
          rdata_d[dsc_pkg::STAT_DLL_LSB +: dsc_pkg::SET_W] = dll_gray_q;
        end
        default: ; // unmapped reads give zero
      endcase
    end
  end

  // setting source, counter stepping and update pulse
  always_comb begin
    dll_bin = dsc_pkg::gray2bin(dll_gray_q);
    dll_gray_d = dll_gray_q;
    if (pd_valid && pd_up && dll_bin != dsc_pkg::GRAY_MAX_BIN) begin
      dll_gray_d = dsc_pkg::bin2gray(dll_bin + 7'h01);
    end else if (pd_valid && !pd_up && dll_bin != '0) begin
      dll_gray_d = dsc_pkg::bin2gray(dll_bin - 7'h01);
    end
    lock_cnt_d = lock_cnt_q;
    locked_d = locked_q;
    if (lock_cnt_q != dsc_pkg::LOCK_CYCLES) begin
      lock_cnt_d = lock_cnt_q + 12'h001;
    end
    if (lock_cnt_d == dsc_pkg::LOCK_CYCLES) begin
      locked_d = 1'b1;
    end
    if (dll_rst) begin
      dll_gray_d = dsc_pkg::GRAY_RST;
      lock_cnt_d = '0;
      locked_d = 1'b0;
    end
    // processor variant has no core path
    sel_delay = (!HAS_PROCESSOR && cfg_q.core_delay) ? core_delay_gray : dll_gray_q;
    pace_tick = cfg_q.upd_user ? user_tick : ref_tick;
    upd_cnt_d = upd_cnt_q;
    upd_en_d = 1'b0;
    if (pace_tick) begin
      if (upd_cnt_q >= UPD_PERIOD - 8'h01) begin
        upd_cnt_d = '0;
        upd_en_d = 1'b1;
      end else begin
        upd_cnt_d = upd_cnt_q + 8'h01;
      end
    end
    held_d = held_q;
    if (upd_en_q) begin
      held_d.delay = sel_delay;
      held_d.phase = phase_reg_q;
    end
  end

  // register port, loop and update state
  always_ff @(posedge clk) begin
    if (reset) begin
      cfg_q <= '0;
      phase_reg_q <= '0;
      lvl_q <= '0;
      rdata_q <= '0;
      dll_gray_q <= dsc_pkg::GRAY_RST;
      lock_cnt_q <= '0;
      locked_q <= 1'b0;
      upd_cnt_q <= '0;
      upd_en_q <= 1'b0;
      held_q <= '0;
    end else if (ce) begin
      cfg_q <= cfg_d;
      phase_reg_q <= phase_reg_d;
      lvl_q <= lvl_d;
      rdata_q <= rdata_d;
      dll_gray_q <= dll_gray_d;
      lock_cnt_q <= lock_cnt_d;
      locked_q <= locked_d;
      upd_cnt_q <= upd_cnt_d;
      upd_en_q <= upd_en_d;
      held_q <= held_d;
    end
  end

  // per strobe state
  logic [NUM_STROBES-1:0] s1_q, s2_q, s3_q; // pin synchroniser
  logic [NUM_STROBES-1:0] filt_q, filt_d; // agreed strobe level
  logic [7:0] hist_q [NUM_STROBES], hist_d [NUM_STROBES]; // strobe delay chains
  logic [NUM_STROBES-1:0] stage_q, stage_d; // first capture of gate enable
  logic [NUM_STROBES-1:0] pa_q, pa_d; // postamble register
  logic [NUM_STROBES-1:0] cap_q, cap_d; // gated shifted strobe
  logic hr_q, hr_d; // half-rate resynchronisation divider
  logic [6:0] tap_sum; // delay plus phase offset
  logic [2:0] tap_idx; // chosen delay tap

  // delay chains and postamble gating
  always_comb begin
    hr_d = ~hr_q;
    tap_sum = dsc_pkg::gray2bin(held_q.delay) + held_q.phase;
    tap_idx = tap_sum[dsc_pkg::TAP_IDX_LSB +: dsc_pkg::TAP_W];
    for (int i = 0; i < NUM_STROBES; i++) begin
      // a change counts once the later two stages agree
      filt_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : filt_q[i];
      hist_d[i] = {hist_q[i][6:0], filt_q[i]};
      // half_rate_stage captures only on the half-rate edge
      stage_d[i] = (cfg_q.hr_stage && !hr_q) ? stage_q[i] : gate_en[i];
      pa_d[i] = stage_q[i];
      // AND delays the rise one cycle, drops at once
      cap_d[i] = hist_q[i][tap_idx] & stage_q[i] & pa_q[i];
    end
  end

  // strobe path registers
  always_ff @(posedge clk) begin
    if (reset) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      filt_q <= '0;
      stage_q <= '0;
      pa_q <= '0;
      cap_q <= '0;
      hr_q <= 1'b0;
      for (int i = 0; i < NUM_STROBES; i++) begin
        hist_q[i] <= '0;
      end
    end else if (ce) begin
      s1_q <= strobe_pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
      filt_q <= filt_d;
      stage_q <= stage_d;
      pa_q <= pa_d;
      cap_q <= cap_d;
      hr_q <= hr_d;
      for (int i = 0; i < NUM_STROBES; i++) begin
        hist_q[i] <= hist_d[i];
      end
    end
  end

  // leveled clock from an eight-tap phase and a select
  function automatic logic lvl_clk(input logic [2:0] ph, input logic [2:0] sel,
                                   input logic [2:0] lag);
    logic [2:0] p;
    p = ph - sel - lag;
    return p < dsc_pkg::HALF_TAPS;
  endfunction : lvl_clk

  // leveling and write clock state
  logic [2:0] ph_q, ph_d; // position of the -90 write clock, 45 degree steps
  logic [NUM_STROBES-1:0] rl_q, rl_d, wls_q, wls_d, wld_q, wld_d;
  logic wrs_q, wrs_d, wrd_q, wrd_d, term_q, term_d;
  logic [2:0] rsel, wsel;

  // tap selection and termination
  always_comb begin
    // one phase counter feeds all leveling taps; the held setting does not trim them
    ph_d = ph_q + 3'h1;
    rsel = '0;
    wsel = '0;
    for (int g = 0; g < NUM_STROBES; g++) begin
      rsel = lvl_q[g*dsc_pkg::LVL_GRP_W +: dsc_pkg::TAP_W];
      wsel = lvl_q[g*dsc_pkg::LVL_GRP_W + dsc_pkg::LVL_WR_LSB +: dsc_pkg::TAP_W];
      rl_d[g] = lvl_clk(ph_q, rsel, '0);
      wls_d[g] = lvl_clk(ph_q, wsel, '0);
      wld_d[g] = lvl_clk(ph_q, wsel, dsc_pkg::LAG_90);
    end
    wrs_d = lvl_clk(ph_q, '0, '0);
    wrd_d = lvl_clk(ph_q, '0, dsc_pkg::LAG_90);
    term_d = term_q;
    if (wr_active) begin
      term_d = 1'b0;
    end else if (rd_active) begin
      term_d = 1'b1;
    end
  end

  // leveling and termination registers
  always_ff @(posedge clk) begin
    if (reset) begin
      ph_q <= '0;
      rl_q <= '0;
      wls_q <= '0;
      wld_q <= '0;
      wrs_q <= 1'b0;
      wrd_q <= 1'b0;
      term_q <= 1'b0;
    end else if (ce) begin
      ph_q <= ph_d;
      rl_q <= rl_d;
      wls_q <= wls_d;
      wld_q <= wld_d;
      wrs_q <= wrs_d;
      wrd_q <= wrd_d;
      term_q <= term_d;
    end
  end

  // outputs straight from flip-flops
  assign rdata = rdata_q;
  assign dq_capture_strobe = cap_q;
  assign upd_en = upd_en_q;
  assign held_delay = held_q.delay;
  assign held_phase = held_q.phase;
  assign locked = locked_q;
  assign parallel_termination = term_q;
  assign wr_strobe_clk = wrs_q;
  assign wr_data_clk = wrd_q;
  assign rl_clk = rl_q;
  assign wl_strobe_clk = wls_q;
  assign wl_data_clk = wld_q;
endmodule : dsc_strobe_logic
`default_nettype wire

// ===== dsc_strobe_logic_assertions.sv
`timescale 1ns/1ps
`default_nettype none
// port checker for the strobe block
module dsc_chk #(
  parameter int NUM_STROBES = 2
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  // settings
  input wire logic upd_en,
  input wire logic [dsc_pkg::SET_W-1:0] held_delay,
  input wire logic [dsc_pkg::SET_W-1:0] held_phase,
  // gate and capture
  input wire logic [NUM_STROBES-1:0] gate_en,
  input wire logic [NUM_STROBES-1:0] dq_capture_strobe,
  // termination and write clocks
  input wire logic rd_active,
  input wire logic wr_active,
  input wire logic parallel_termination,
  input wire logic wr_strobe_clk,
  input wire logic wr_data_clk,
  input wire logic [NUM_STROBES-1:0] wl_strobe_clk,
  input wire logic [NUM_STROBES-1:0] wl_data_clk
);
  // active cycles since reset or a freeze, saturating at eight
  logic [3:0] run_q;
  always_ff @(posedge clk) begin
    if (reset || !ce) begin
      run_q <= '0;
    end else if (!run_q[3]) begin
      run_q <= run_q + 4'h1;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (reset || !ce);
  chk_upd_single: assert property (upd_en |=> !upd_en)
    else $error("update enable held past one cycle");
  chk_held_load: assert property (!upd_en |=> $stable({held_delay, held_phase}))
    else $error("held settings moved without update enable");
  chk_term_read: assert property (rd_active && !wr_active |=> parallel_termination)
    else $error("termination off during read");
  chk_term_write: assert property (wr_active |=> !parallel_termination)
    else $error("termination on during write");
  chk_wr_lag: assert property (run_q[3] && $rose(wr_data_clk)
    |-> $past(wr_strobe_clk, 2) && !$past(wr_strobe_clk, 3))
    else $error("write data clock not behind strobe clock");
  chk_wl_lag: assert property (run_q[3] && $rose(wl_data_clk[0])
    |-> $past(wl_strobe_clk[0], 2) && !$past(wl_strobe_clk[0], 3))
    else $error("leveled data clock not behind strobe clock");
  chk_gate_off: assert property (!gate_en[0] [*3] |=> !dq_capture_strobe[0])
    else $error("capture strobe passed a closed gate");
  chk_gate_on: assert property ($rose(gate_en[0]) |=> !dq_capture_strobe[0] [*2])
    else $error("gate opened too early");
endmodule : dsc_chk
bind dsc_strobe_logic dsc_chk #(.NUM_STROBES(NUM_STROBES)) u_chk (
  .clk(clk), .reset(reset), .ce(ce), .upd_en(upd_en), .held_delay(held_delay),
  .held_phase(held_phase), .gate_en(gate_en), .dq_capture_strobe(dq_capture_strobe),
  .rd_active(rd_active), .wr_active(wr_active),
  .parallel_termination(parallel_termination), .wr_strobe_clk(wr_strobe_clk),
  .wr_data_clk(wr_data_clk), .wl_strobe_clk(wl_strobe_clk), .wl_data_clk(wl_data_clk));
`default_nettype wire

// ===== testbench.sv
`timescale 1ns/1ps
`default_nettype none
// self-checking bench for the strobe block
module testbench;
  logic clk, reset, ce, wr, rd, pd_valid, pd_up, ref_tick, user_tick, go;
  logic rd_active, wr_active, upd_en, locked, term, wsc, wdc;
  logic [3:0] addr;
  logic [31:0] wdata, rdata, v, frz;
  logic [6:0] cdg, held_delay, held_phase, k, p;
  logic [1:0] strobe_pin, gate_en, cap, rl, wls, wld;
  logic [15:0] r0, r1, s0, s1; // sampled leveled clocks
  int fails = 0, checked = 0, cyc = 0, n, hits, caps;
  // one interface in the sub-bank, short update pacing
  dsc_strobe_logic #(.NUM_STROBES(2), .UPD_PERIOD(8'h02)) u_dut (
    .clk(clk), .reset(reset), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .pd_valid(pd_valid), .pd_up(pd_up), .core_delay_gray(cdg),
    .ref_tick(ref_tick), .user_tick(user_tick), .strobe_pin(strobe_pin),
    .gate_en(gate_en), .dq_capture_strobe(cap), .upd_en(upd_en),
    .held_delay(held_delay), .held_phase(held_phase), .locked(locked),
    .rd_active(rd_active), .wr_active(wr_active), .parallel_termination(term),
    .wr_strobe_clk(wsc), .wr_data_clk(wdc), .rl_clk(rl), .wl_strobe_clk(wls),
    .wl_data_clk(wld));
  // memory on the far side
  dsc_mem_model #(.N(2)) u_mem (.clk(clk), .go(go), .strobe(strobe_pin));
  // outputs packed for the freeze check
  assign frz = 32'({wsc, wdc, rl, wls, wld, upd_en, locked, term, held_delay, held_phase});
  // expected gray code of a binary count
  function automatic logic [6:0] gray(input logic [6:0] b);
    return b ^ (b >> 1);
  endfunction : gray
  // compare seen against expected
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      fails++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  // one-cycle register write
  task automatic wreg(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    {addr, wdata, wr} <= {a, d, 1'b1};
    @(posedge clk);
    wr <= 1'b0;
  endtask : wreg
  // one-cycle register read into v
  task automatic rreg(input logic [3:0] a);
    @(posedge clk);
    {addr, rd} <= {a, 1'b1};
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask : rreg
  // wait for an update pulse, then for the load after it
  task automatic wupd();
    repeat (2) @(posedge clk);
    #1 n = 0;
    while (upd_en !== 1'b1 && n < 200) begin
      @(posedge clk);
      #1 n++;
    end
    @(posedge clk);
    #1;
  endtask : wupd
  // count update pulses and capture strobes
  task automatic cnt(input int c);
    {hits, caps} = '0;
    repeat (c) begin
      @(posedge clk);
      #1 hits += int'(upd_en === 1'b1);
      caps += int'((|cap) === 1'b1);
    end
  endtask : cnt
  // verdict and end of run
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : finish_test
  // clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // random reference pacing ticks
  always @(posedge clk) ref_tick <= 1'($urandom_range(1, 0));
  // run-length limit
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      finish_test();
    end
  end
  // main sequence
  initial begin
    {reset, ce} = 2'b11;
    {addr, wdata, cdg, gate_en, wr, rd, pd_valid, pd_up, user_tick} = '0;
    {rd_active, wr_active, go} = '0;
    void'($urandom(30));
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    // leveling taps: group 1 reads two taps and writes one tap later
    wreg(dsc_pkg::REG_LVL, 32'h0000_0A00);
    rreg(dsc_pkg::REG_LVL);
    chk("lvl", v, 32'h0000_0A00);
    for (int i = 0; i < 16; i++) begin
      @(posedge clk);
      #1 {r0[i], r1[i], s0[i], s1[i]} = {rl[0], rl[1], wls[0], wls[1]};
    end
    chk("rl lag", r1[15:2], r0[13:0]);
    chk("wl lag", s1[15:1], s0[14:0]);
    // calibration sweep: every write tap of group 1 against group 0
    for (int t = 0; t < 8; t++) begin
      wreg(dsc_pkg::REG_LVL, 32'h0000_0200 | (32'(t) << 11));
      for (int i = 0; i < 16; i++) begin
        @(posedge clk);
        #1 {s0[i], s1[i]} = {wls[0], wls[1]};
      end
      chk("wl sweep", s1[15:8], s0[15-t -: 8]);
    end
    $display("test leveling done");
    rreg(dsc_pkg::REG_STATUS);
    chk("status", v, 32'h0);
    rreg(4'h9);
    chk("unmapped", v, 32'h0);
    // loop counter steps up k times
    k = 7'($urandom_range(40, 5));
    @(posedge clk);
    {pd_valid, pd_up} <= 2'b11;
    repeat (k) @(posedge clk);
    pd_valid <= 1'b0;
    rreg(dsc_pkg::REG_STATUS);
    chk("loop up", v[22:16], gray(k));
    // new phase reaches the chains only through an update
    p = 7'($urandom);
    wreg(dsc_pkg::REG_PHASE, {25'h0, p});
    wupd();
    chk("held phase", held_phase, p);
    chk("held delay", held_delay, gray(k));
    // core-supplied setting
    @(posedge clk);
    cdg <= 7'($urandom);
    wreg(dsc_pkg::REG_CTRL, 32'h1);
    wupd();
    chk("core delay", held_delay, cdg);
    $display("test settings done");
    // user pacing: quiet without ticks, then every second tick
    wreg(dsc_pkg::REG_CTRL, 32'h2);
    repeat (3) @(posedge clk);
    cnt(30);
    chk("user idle", hits, 0);
    @(posedge clk);
    user_tick <= 1'b1;
    cnt(20);
    chk("user pace", hits >= 8 && hits <= 11, 1);
    @(posedge clk);
    user_tick <= 1'b0;
    $display("test pacing done");
    // read burst through the gate, plain and with half_rate_stage
    for (int m = 0; m < 2; m++) begin
      wreg(dsc_pkg::REG_CTRL, 32'(m) << dsc_pkg::CTRL_HR_STAGE);
      {gate_en, go} <= 3'b111;
      @(posedge clk);
      go <= 1'b0;
      cnt(30);
      chk("gate open", caps != 0, 1);
      @(posedge clk);
      gate_en <= '0;
      repeat (4) @(posedge clk);
      cnt(20);
      chk("gate closed", caps, 0);
    end
    $display("test gate done");
    // termination: read on, write wins, idle holds
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      {rd_active, wr_active} <= 2'(8'h2E >> (2 * i));
      repeat (2) @(posedge clk);
      #1 chk("term", term, 32'(4'hD >> i) & 32'h1);
    end
    $display("test termination done");
    // clock enable low freezes every output; the check covers all but rdata and the capture strobes; pacing quiet so no update is pending
    wreg(dsc_pkg::REG_CTRL, 32'h2);
    @(posedge clk);
    ce <= 1'b0;
    repeat (2) @(posedge clk);
    #1 v = frz;
    repeat (6) @(posedge clk);
    #1 chk("freeze", frz, v);
    @(posedge clk);
    ce <= 1'b1;
    $display("test freeze done");
    // loop restart and lock time
    wreg(dsc_pkg::REG_CTRL, 32'h8);
    repeat (2559) @(posedge clk);
    #1 chk("lock early", locked, 0);
    n = 0;
    while (locked !== 1'b1 && n < 200) begin
      @(posedge clk);
      #1 n++;
    end
    chk("lock time", n, 1);
    $display("test lock done");
    finish_test();
  end
endmodule : testbench
`default_nettype wire
